/* src/deb_pkg.sv */
// Shared constants and types for the external bus and interrupt pin block.
// Assumes one core clock; users write deb_pkg::name.
package deb_pkg;

  // Widths of the external bus
  localparam int ADDR_W = 20;
  localparam int LOW_ADDR_W = 16;
  localparam int DATA_W = 16;
  localparam int NUM_IRQ = 4;

  // Register offsets on the plain register port
  localparam logic [7:0] OFF_BANK_SWITCH_CTRL = 8'h00;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h04;
  localparam logic [7:0] OFF_IRQ_PENDING = 8'h08;
  localparam logic [7:0] OFF_CORE_CTRL = 8'h0c;
  localparam logic [7:0] OFF_BUS_STATUS = 8'h10;

  // Bank switch control fields
  localparam int BANK_SWITCH_CTRL_REG_KEEPER_BIT = 0;
  localparam int BANK_SWITCH_CTRL_REG_WAIT_LSB = 1;
  localparam int WAIT_W = 3;
  // Core control fields
  localparam int CTRL_GID_BIT = 0;
  // Pending register: bits 3..0 external, bit 4 non-maskable
  localparam int PEND_NMI_BIT = 4;
  localparam int PEND_W = 5;

  // Reset values
  localparam logic RST_KEEPER_EN = 1'b0;
  localparam logic [2:0] RST_WAIT_STATES = 3'h0;
  localparam logic [3:0] RST_IRQ_MASK = 4'h0;
  localparam logic RST_GID = 1'b1;

  // Ready is only looked at with at least this many software wait states
  localparam logic [2:0] READY_MIN_WAIT = 3'h2;

  // Vector locations in program space
  localparam logic [15:0] VEC_EXT_BASE = 16'hffc0;
  localparam logic [15:0] VEC_NMI = 16'hff88;
  localparam int VEC_STRIDE_SHIFT = 2;

  // External address spaces
  typedef enum logic [1:0] {SPACE_PROG, SPACE_DATA, SPACE_IO} deb_space_t;

  // Access sequencer states
  typedef enum logic [1:0] {ST_IDLE, ST_ADDR, ST_WAIT, ST_END} deb_state_t;

endpackage

/* src/deb_pin_sync.sv */
// Two-stage synchroniser for a group of pin inputs.
// Assumes asynchronous pins; only the second stage is read.
`timescale 1ns/1ns
`default_nettype none
module deb_pin_sync #(
  parameter int WIDTH = 8,
  parameter logic [WIDTH-1:0] RST_VAL = '1
) (
  input wire logic sys_clk, // Core clock
  input wire logic rstn, // Asynchronous reset, active low
  input wire logic clkEn, // Freezes the stages while low
  input wire logic [WIDTH-1:0] pinIn, // Raw pin levels
  output logic [WIDTH-1:0] pinSync // Levels after two flip-flops
);

  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stable;
  } deb_sync_t;

  deb_sync_t s_q;
  deb_sync_t s_d;

  initial begin
    if (WIDTH < 1) $error("deb_pin_sync: WIDTH must be at least 1");
  end

  // Stage one feeds stage two and nothing else
  always_comb begin
    s_d = s_q;
    s_d.meta = pinIn;
    s_d.stable = s_q.meta;
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      s_q <= {RST_VAL, RST_VAL};
    end else if (clkEn) begin
      s_q <= s_d;
    end
  end

  assign pinSync = s_q.stable;

endmodule
`default_nettype wire

/* src/deb_ext_bus.sv */
// External parallel bus pins and external interrupt inputs of the DSP core.
// Assumes pins are asynchronous, the core issues accesses on a request port,
// and pads honour active-low drive enables.
//
// Function
// - Twenty address outputs; top four used only for program-space accesses.
// - Low sixteen address outputs are shared by program, data and I/O accesses.
// - Address outputs float in hold mode or while output-disable is low.
// - Sixteen-bit words move over one bidirectional data bus.
// - Data bus floats unless writing, and while reset or hold is asserted.
// - Data bus floats whenever output-disable is low, whatever the access.
// - Enabled keepers hold each data pin at its last level while undriven.
// - Keepers reset disabled; a bank switch control bit turns them on or off.
// - Acknowledge is asserted during vector fetch; vector goes on the low address.
// - Acknowledge output floats whenever output-disable is low.
// - Four maskable interrupts in fixed priority, gated by mask and global disable.
// - Each maskable request is visible in the pending register and cleared there.
// - The non-maskable input is taken regardless of global disable and mask.
// - The non-maskable interrupt fetches from its own dedicated vector.
// - Space selects idle high, low only during their own access while address is valid.
// - Memory strobe idles high, low only for program or data memory accesses.
// - Direction output stays high for read, low only during an external write.
// - Ready low stretches an access only with two or more software wait states; checked each cycle after them.
`timescale 1ns/1ns
`default_nettype none
module deb_ext_bus #(
  parameter int WAIT_W = deb_pkg::WAIT_W
) (
  input wire logic sys_clk, // Core clock, 10 MHz
  input wire logic rstn, // Asynchronous reset, active low
  input wire logic clkEn, // Freezes all state while low
  // Register port
  input wire logic [7:0] regAddr, // Byte address
  input wire logic [31:0] regWdata, // Write data
  input wire logic regWr, // Write strobe
  input wire logic regRd, // Read strobe
  output logic [31:0] regRdata, // Read data, cycle after the strobe
  output logic irqOut, // Level interrupt to the core
  // Core access request port
  input wire logic reqValid, // Access request
  input wire logic [1:0] reqSpace, // Target space, deb_space_t code
  input wire logic reqWrite, // 1 for write
  input wire logic [19:0] reqAddr, // Full access address
  input wire logic [15:0] reqWdata, // Write word
  output logic reqReady, // Sequencer can take a request
  output logic rspValid, // One-cycle completion pulse
  output logic [15:0] rspRdata, // Read word, valid with rspValid
  input wire logic irqTakeEn, // Core may take an interrupt now
  output logic vecTaken, // One-cycle pulse when a vector fetch ends
  output logic [15:0] vecAddr, // Vector address of the last fetch
  // Pins
  input wire logic reset_pin_n, // Reset pin, active low
  input wire logic outputDisableN, // Global output disable, active low
  input wire logic holdReqN, // Bus release request, active low
  output logic holdAckN, // Bus released, active low
  input wire logic ready, // External ready
  input wire logic ext_irq_0_n, // External interrupt 0, highest priority
  input wire logic ext_irq_1_n, // External interrupt 1
  input wire logic ext_irq_2_n, // External interrupt 2
  input wire logic ext_irq_3_n, // External interrupt 3
  input wire logic nmiN, // Non-maskable interrupt, falling edge
  output logic [19:0] addrOut, // Address pins
  output logic addrDrvN, // Address drive enable, low drives
  input wire logic [15:0] dataIn, // Data pin levels
  output logic [15:0] dataOut, // Data pin drive value
  output logic dataDrvN, // Data drive enable, low drives
  output logic bus_keeper_enable, // Keeper enable to the data pads
  output logic [15:0] keeperLevel, // Level the keepers hold
  output logic program_space_sel_n, // Program space select
  output logic data_space_sel_n, // Data space select
  output logic io_space_sel_n, // I/O space select
  output logic mem_strobe_n, // Memory strobe
  output logic io_access_strobe_n, // I/O strobe
  output logic readWriteN, // High read, low write
  output logic ctlDrvN, // Control pins drive enable, low drives
  output logic irq_acknowledge_n, // Vector fetch acknowledge
  output logic iackDrvN // Acknowledge drive enable, low drives
);

  localparam int SYNC_W = 9 + deb_pkg::DATA_W;

  typedef struct packed {
    deb_pkg::deb_state_t state;
    logic [WAIT_W-1:0] waitCnt;
    logic [19:0] addr;
    logic [15:0] wdata;
    logic write;
    deb_pkg::deb_space_t space;
    logic vecFetch;
    logic [deb_pkg::PEND_W-1:0] vecBit;
    logic keeperEn;
    logic [WAIT_W-1:0] waitStates;
    logic [3:0] irqMask;
    logic [deb_pkg::PEND_W-1:0] pending;
    logic globalIrqDisable;
    logic [deb_pkg::PEND_W-1:0] irqPrev;
    logic holdMode;
    logic [31:0] regRdata;
    logic irqOut;
    logic reqReady;
    logic rspValid;
    logic [15:0] rspRdata;
    logic vecTaken;
    logic [15:0] vecAddr;
    logic [19:0] addrOut;
    logic addrDrvN;
    logic [15:0] dataOut;
    logic dataDrvN;
    logic [15:0] keeperLevel;
    logic psN;
    logic dsN;
    logic isN;
    logic mstrbN;
    logic iostrbN;
    logic rwN;
    logic ctlDrvN;
    logic iackN;
    logic iackDrvN;
  } deb_bus_t;

  deb_bus_t s_q;
  deb_bus_t s_d;

  logic [SYNC_W-1:0] pinRaw;
  logic [SYNC_W-1:0] pinSync;
  logic [deb_pkg::PEND_W-1:0] irqSync;
  logic readySync;
  logic holdSync;
  logic resetPinSync;
  logic outDisSync;
  logic [15:0] dataSync;

  initial begin
    if (WAIT_W < 2 || WAIT_W > 8) $error("deb_ext_bus: WAIT_W must lie in 2..8");
  end

  // All asynchronous pins pass two flip-flops first
  assign pinRaw = {dataIn, outputDisableN, reset_pin_n, holdReqN, ready, nmiN,
                   ext_irq_3_n, ext_irq_2_n, ext_irq_1_n, ext_irq_0_n};

  deb_pin_sync #(
    .WIDTH(SYNC_W),
    .RST_VAL({SYNC_W{1'b1}})
  ) u_pin_sync (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .clkEn(clkEn),
    .pinIn(pinRaw),
    .pinSync(pinSync)
  );

  // Unpack the synchronised pin group
  assign irqSync = pinSync[4:0];
  assign readySync = pinSync[5];
  assign holdSync = ~pinSync[6];
  assign resetPinSync = ~pinSync[7];
  assign outDisSync = ~pinSync[8];
  assign dataSync = pinSync[SYNC_W-1:9];

  // Next-state logic for the whole block
  always_comb begin
    logic [deb_pkg::PEND_W-1:0] irqFall;
    logic [deb_pkg::PEND_W-1:0] clrBits;
    logic [3:0] eligible;
    logic takeIrq;
    logic [deb_pkg::PEND_W-1:0] pick;
    logic [15:0] pickVec;
    logic floatCtl;
    logic accessOn;
    logic waitDone;
    irqFall = '0;
    clrBits = '0;
    eligible = '0;
    takeIrq = 1'b0;
    pick = '0;
    pickVec = '0;
    floatCtl = 1'b0;
    accessOn = 1'b0;
    waitDone = 1'b0;
    s_d = s_q;
    s_d.rspValid = 1'b0;
    s_d.vecTaken = 1'b0;
    s_d.regRdata = '0;

    // Falling edges of synchronised interrupt pins
    irqFall = s_q.irqPrev & ~irqSync;
    s_d.irqPrev = irqSync;

    // Register writes; pending bits clear by writing one
    if (regWr) begin
      if (regAddr == deb_pkg::OFF_BANK_SWITCH_CTRL) begin
        s_d.keeperEn = regWdata[deb_pkg::BANK_SWITCH_CTRL_REG_KEEPER_BIT];
        s_d.waitStates = regWdata[deb_pkg::BANK_SWITCH_CTRL_REG_WAIT_LSB +: WAIT_W];
      end else if (regAddr == deb_pkg::OFF_IRQ_MASK) begin
        s_d.irqMask = regWdata[3:0];
      end else if (regAddr == deb_pkg::OFF_IRQ_PENDING) begin
        clrBits = regWdata[deb_pkg::PEND_W-1:0];
      end else if (regAddr == deb_pkg::OFF_CORE_CTRL) begin
        s_d.globalIrqDisable = regWdata[deb_pkg::CTRL_GID_BIT];
      end
    end

    // Reads answer next cycle; unmapped read zero
    if (regRd) begin
      if (regAddr == deb_pkg::OFF_BANK_SWITCH_CTRL) begin
        s_d.regRdata[deb_pkg::BANK_SWITCH_CTRL_REG_KEEPER_BIT] = s_q.keeperEn;
        s_d.regRdata[deb_pkg::BANK_SWITCH_CTRL_REG_WAIT_LSB +: WAIT_W] = s_q.waitStates;
      end else if (regAddr == deb_pkg::OFF_IRQ_MASK) begin
        s_d.regRdata[3:0] = s_q.irqMask;
      end else if (regAddr == deb_pkg::OFF_IRQ_PENDING) begin
        s_d.regRdata[deb_pkg::PEND_W-1:0] = s_q.pending;
      end else if (regAddr == deb_pkg::OFF_CORE_CTRL) begin
        s_d.regRdata[deb_pkg::CTRL_GID_BIT] = s_q.globalIrqDisable;
      end else if (regAddr == deb_pkg::OFF_BUS_STATUS) begin
        s_d.regRdata[1:0] = s_q.state;
        s_d.regRdata[2] = s_q.holdMode;
        s_d.regRdata[3] = s_q.vecFetch;
      end
    end

    // Fixed priority: non-maskable first, then input 0 down to 3
    eligible = s_q.pending[3:0] & s_q.irqMask & {4{~s_q.globalIrqDisable}};
    if (s_q.pending[deb_pkg::PEND_NMI_BIT]) begin
      pick[deb_pkg::PEND_NMI_BIT] = 1'b1;
      pickVec = deb_pkg::VEC_NMI;
    end else begin
      for (int i = deb_pkg::NUM_IRQ - 1; i >= 0; i--) begin
        if (eligible[i]) begin
          pick = '0;
          pick[i] = 1'b1;
          pickVec = deb_pkg::VEC_EXT_BASE + 16'(i << deb_pkg::VEC_STRIDE_SHIFT);
        end
      end
    end
    takeIrq = irqTakeEn && (pick != '0);

    // Hold mode is entered only between accesses
    if (s_q.state == deb_pkg::ST_IDLE) begin
      s_d.holdMode = holdSync;
    end

    // Access sequencer
    case (s_q.state)
      deb_pkg::ST_IDLE: begin
        if (!s_q.holdMode && !holdSync && !resetPinSync) begin
          if (takeIrq) begin
            // Vector fetch is a program read at the low address
            s_d.state = deb_pkg::ST_ADDR;
            s_d.vecFetch = 1'b1;
            s_d.vecBit = pick;
            s_d.addr = {4'h0, pickVec};
            s_d.space = deb_pkg::SPACE_PROG;
            s_d.write = 1'b0;
            s_d.globalIrqDisable = 1'b1;
            clrBits = clrBits | pick;
          end else if (reqValid && s_q.reqReady) begin
            s_d.state = deb_pkg::ST_ADDR;
            s_d.vecFetch = 1'b0;
            s_d.space = deb_pkg::deb_space_t'(reqSpace);
            s_d.write = reqWrite;
            s_d.wdata = reqWdata;
            // Upper four bits only reach the pins for program space
            s_d.addr = (reqSpace == deb_pkg::SPACE_PROG) ? reqAddr : {4'h0, reqAddr[15:0]};
          end
        end
      end
      deb_pkg::ST_ADDR: begin
        s_d.state = deb_pkg::ST_WAIT;
        s_d.waitCnt = s_q.waitStates;
      end
      deb_pkg::ST_WAIT: begin
        if (s_q.waitCnt != '0) begin
          s_d.waitCnt = s_q.waitCnt - 1'b1;
        end else begin
          // Ready looked at once software wait states are spent, only if there are at least READY_MIN_WAIT
          waitDone = (s_q.waitStates < WAIT_W'(deb_pkg::READY_MIN_WAIT)) || readySync;
          if (waitDone) begin
            s_d.state = deb_pkg::ST_END;
          end
        end
      end
      deb_pkg::ST_END: begin
        s_d.state = deb_pkg::ST_IDLE;
        s_d.rspRdata = dataSync;
        if (s_q.vecFetch) begin
          s_d.vecTaken = 1'b1;
          s_d.vecAddr = s_q.addr[15:0];
        end else begin
          s_d.rspValid = 1'b1;
        end
        s_d.vecFetch = 1'b0;
      end
      default: begin
        s_d.state = deb_pkg::ST_IDLE;
      end
    endcase

    // Reset pin aborts any access in flight
    if (resetPinSync) begin
      s_d.state = deb_pkg::ST_IDLE;
      s_d.vecFetch = 1'b0;
    end

    // Set wins over a same-cycle clear
    s_d.pending = (s_q.pending & ~clrBits) | irqFall;
    s_d.irqOut = |(s_d.pending[3:0] & s_d.irqMask) || s_d.pending[deb_pkg::PEND_NMI_BIT];
    s_d.reqReady = (s_d.state == deb_pkg::ST_IDLE) && !s_d.holdMode && !holdSync && !resetPinSync;

    // Pin outputs, registered from the next state
    accessOn = (s_d.state == deb_pkg::ST_ADDR) || (s_d.state == deb_pkg::ST_WAIT);
    floatCtl = s_d.holdMode || outDisSync;
    s_d.addrOut = s_d.addr;
    s_d.addrDrvN = floatCtl;
    s_d.ctlDrvN = floatCtl;
    s_d.psN = !(accessOn && s_d.space == deb_pkg::SPACE_PROG);
    s_d.dsN = !(accessOn && s_d.space == deb_pkg::SPACE_DATA);
    s_d.isN = !(accessOn && s_d.space == deb_pkg::SPACE_IO);
    s_d.mstrbN = !(accessOn && s_d.space != deb_pkg::SPACE_IO);
    s_d.iostrbN = !(accessOn && s_d.space == deb_pkg::SPACE_IO);
    s_d.rwN = !(accessOn && s_d.write);
    s_d.dataOut = s_d.wdata;
    // Drive data only for a write, never in reset, hold or output-disable
    s_d.dataDrvN = !(accessOn && s_d.write) || resetPinSync || holdSync || s_d.holdMode || outDisSync;
    s_d.iackN = !(accessOn && s_d.vecFetch);
    s_d.iackDrvN = outDisSync;

    // Keeper level tracks what was driven, else, with keepers enabled, what the pins last showed
    if (!s_q.dataDrvN) begin
      s_d.keeperLevel = s_q.dataOut;
    end else if (s_q.keeperEn) begin
      s_d.keeperLevel = dataSync;
    end
  end

  // State register; reset idles pins, floats data
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      s_q <= '0;
      s_q.state <= deb_pkg::ST_IDLE;
      s_q.space <= deb_pkg::SPACE_PROG;
      s_q.keeperEn <= deb_pkg::RST_KEEPER_EN;
      s_q.waitStates <= WAIT_W'(deb_pkg::RST_WAIT_STATES);
      s_q.irqMask <= deb_pkg::RST_IRQ_MASK;
      s_q.globalIrqDisable <= deb_pkg::RST_GID;
      s_q.irqPrev <= '1;
      s_q.addrDrvN <= 1'b0;
      s_q.dataDrvN <= 1'b1;
      s_q.psN <= 1'b1;
      s_q.dsN <= 1'b1;
      s_q.isN <= 1'b1;
      s_q.mstrbN <= 1'b1;
      s_q.iostrbN <= 1'b1;
      s_q.rwN <= 1'b1;
      s_q.iackN <= 1'b1;
    end else if (clkEn) begin
      s_q <= s_d;
    end
  end

  // Outputs straight from the state register
  assign regRdata = s_q.regRdata;
  assign irqOut = s_q.irqOut;
  assign reqReady = s_q.reqReady;
  assign rspValid = s_q.rspValid;
  assign rspRdata = s_q.rspRdata;
  assign vecTaken = s_q.vecTaken;
  assign vecAddr = s_q.vecAddr;
  assign holdAckN = ~s_q.holdMode;
  assign addrOut = s_q.addrOut;
  assign addrDrvN = s_q.addrDrvN;
  assign dataOut = s_q.dataOut;
  assign dataDrvN = s_q.dataDrvN;
  assign bus_keeper_enable = s_q.keeperEn;
  assign keeperLevel = s_q.keeperLevel;
  assign program_space_sel_n = s_q.psN;
  assign data_space_sel_n = s_q.dsN;
  assign io_space_sel_n = s_q.isN;
  assign mem_strobe_n = s_q.mstrbN;
  assign io_access_strobe_n = s_q.iostrbN;
  assign readWriteN = s_q.rwN;
  assign ctlDrvN = s_q.ctlDrvN;
  assign irq_acknowledge_n = s_q.iackN;
  assign iackDrvN = s_q.iackDrvN;

endmodule
`default_nettype wire

/* tb/deb_ext_bus_props.sv */
// Concurrent checks on the external bus and interrupt pins.
// Assumes a bind into deb_ext_bus; sees only its ports.
`timescale 1ns/1ns
`default_nettype none
module deb_ext_bus_props #(
  parameter int WAIT_W = deb_pkg::WAIT_W
) (
  input wire logic sys_clk, // Core clock
  input wire logic rstn, // Reset, active low
  input wire logic outputDisableN, // Global output disable
  input wire logic holdAckN, // Bus released
  input wire logic [19:0] addrOut, // Address pins
  input wire logic addrDrvN, // Address drive enable
  input wire logic dataDrvN, // Data drive enable
  input wire logic bus_keeper_enable, // Keeper enable
  input wire logic program_space_sel_n, // Program select
  input wire logic data_space_sel_n, // Data select
  input wire logic io_space_sel_n, // I/O select
  input wire logic mem_strobe_n, // Memory strobe
  input wire logic io_access_strobe_n, // I/O strobe
  input wire logic readWriteN, // Direction
  input wire logic ctlDrvN, // Control drive enable
  input wire logic irq_acknowledge_n, // Acknowledge
  input wire logic iackDrvN, // Acknowledge drive enable
  input wire logic vecTaken, // Vector fetch done
  input wire logic [15:0] vecAddr // Vector address
);
  // One clock, one reset
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rstn);

  a_sel_onehot: assert property ($onehot0({!program_space_sel_n, !data_space_sel_n, !io_space_sel_n}))
    else $error("two space selects low at once");
  a_mem_strobe: assert property (mem_strobe_n == (program_space_sel_n && data_space_sel_n))
    else $error("memory strobe out of step with selects");
  a_io_strobe: assert property (io_access_strobe_n == io_space_sel_n)
    else $error("io strobe out of step with io select");
  a_upper_zero: assert property ((!data_space_sel_n || !io_space_sel_n) |-> addrOut[19:16] == 4'h0)
    else $error("upper address used outside program space");
  a_write_dir: assert property (!readWriteN |-> !(program_space_sel_n && data_space_sel_n && io_space_sel_n))
    else $error("write direction without an access");
  a_data_write: assert property (!dataDrvN |-> !readWriteN)
    else $error("data driven outside a write");
  a_hold_float: assert property (!holdAckN [*2] |-> addrDrvN && dataDrvN && ctlDrvN)
    else $error("pins driven in hold mode");
  a_off_float: assert property (!outputDisableN [*5] |-> addrDrvN && dataDrvN && ctlDrvN && iackDrvN)
    else $error("pins driven while outputs disabled");
  a_irq_acknowledge_n_fetch: assert property (!irq_acknowledge_n |-> !program_space_sel_n && readWriteN)
    else $error("acknowledge outside a program read");
  a_irq_acknowledge_n_end: assert property ($fell(irq_acknowledge_n) |-> ##[1:40] vecTaken)
    else $error("vector fetch never ended");
  a_vec_loc: assert property (vecTaken |-> vecAddr == deb_pkg::VEC_NMI ||
      (vecAddr[15:4] == deb_pkg::VEC_EXT_BASE[15:4] && vecAddr[1:0] == 2'h0))
    else $error("vector fetched from an unknown location");
  a_keeper_reset: assert property ($rose(rstn) |-> !bus_keeper_enable)
    else $error("keepers enabled out of reset");
endmodule
`default_nettype wire

/* tb/deb_ext_mem.sv */
// Behavioural memory and I/O device on the parallel bus pins.
// Assumes one word per low address nibble, all spaces.
`timescale 1ns/1ns
`default_nettype none
module deb_ext_mem (
  input wire logic sys_clk, // Core clock
  input wire logic [19:0] addrOut, // Address pins
  input wire logic [15:0] dataOut, // Bus block drive value
  input wire logic dataDrvN, // Bus block drives data when low
  input wire logic mem_strobe_n, // Memory strobe
  input wire logic io_access_strobe_n, // I/O strobe
  input wire logic readWriteN, // High read
  input wire logic bus_keeper_enable, // Keepers on
  input wire logic [15:0] keeperLevel, // Level the keepers hold
  input wire logic slow, // Stretch every access
  output logic ready, // Ready pin
  output logic [15:0] dataIn, // Resolved data pin level
  output logic [19:0] lastAddr = 20'h0 // Address of the latest access
);
  logic [15:0] mem [16];
  logic [15:0] lastLevel = 16'h0;
  logic [3:0] stallCnt = 4'h0;
  logic active;
  assign active = !mem_strobe_n || !io_access_strobe_n;
  // Slow: ready low for six strobe cycles
  assign ready = !(slow && stallCnt < 4'h6);
  // Floating bus inverts so stale data never looks valid
  always_comb begin
    if (!dataDrvN) dataIn = dataOut;
    else if (active && readWriteN) dataIn = mem[addrOut[3:0]];
    else if (bus_keeper_enable) dataIn = keeperLevel;
    else dataIn = ~lastLevel;
  end
  // Writes, stall count and last address
  always_ff @(posedge sys_clk) begin
    lastLevel <= dataIn;
    stallCnt <= active ? (stallCnt == 4'hf ? stallCnt : stallCnt + 4'h1) : 4'h0;
    if (active) lastAddr <= addrOut;
    if (active && !readWriteN && !dataDrvN) mem[addrOut[3:0]] <= dataOut;
  end
endmodule
`default_nettype wire

/* tb/deb_ext_bus_tb.sv */
// Self-checking bench for the external bus and interrupt pin block.
// Assumes the memory model on the pins and the bound checker.
`timescale 1ns/1ns
`default_nettype none
module deb_ext_bus_tb;
  typedef struct packed {
    logic [1:0] sp;
    logic wr;
    logic [19:0] a;
    logic [15:0] wd;
    logic [15:0] rd;
    logic [19:0] seen;
  } deb_row_t;
  // Write then read per space; upper bits seen only for program
  deb_row_t rows [6] = '{
    '{2'h0, 1'b1, 20'ha0003, 16'h1234, 16'h0, 20'ha0003},
    '{2'h1, 1'b1, 20'h50005, 16'h5678, 16'h0, 20'h00005},
    '{2'h2, 1'b1, 20'h3000a, 16'h9abc, 16'h0, 20'h0000a},
    '{2'h0, 1'b0, 20'ha0003, 16'h0, 16'h1234, 20'ha0003},
    '{2'h1, 1'b0, 20'h50005, 16'h0, 16'h5678, 20'h00005},
    '{2'h2, 1'b0, 20'h3000a, 16'h0, 16'h9abc, 20'h0000a}};
  logic [7:0] regs [6] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h20};
  logic [31:0] rstv [6] = '{32'h0, 32'h0, 32'h0, 32'h1, 32'h0, 32'h0};
  logic sys_clk, regWr = 1'b0, regRd = 1'b0, reqValid = 1'b0, reqWrite = 1'b0, rstn = 1'b0, slow = 1'b0;
  logic reset_pin_n = 1'b1, outputDisableN = 1'b1, holdReqN = 1'b1, ready;
  logic [4:0] irqN = 5'h1f;
  logic [7:0] regAddr = 8'h0;
  logic [31:0] regWdata = 32'h0, regRdata, rv;
  logic [1:0] reqSpace = 2'h0;
  logic [19:0] reqAddr = 20'h0, addrOut, lastAddr;
  logic [15:0] reqWdata = 16'h0, rspRdata, vecAddr, dataIn, dataOut, keeperLevel, rdw;
  logic irqOut, reqReady, rspValid, vecTaken, holdAckN, addrDrvN, dataDrvN, bus_keeper_enable, ctlDrvN;
  logic program_space_sel_n, data_space_sel_n, io_space_sel_n, mem_strobe_n, io_access_strobe_n;
  logic readWriteN, irq_acknowledge_n, iackDrvN;
  int failures = 0, samples_checked = 0, cycles = 0, lat;

  deb_ext_bus u_dut (.*, .clkEn(1'b1), .irqTakeEn(1'b1), .ext_irq_0_n(irqN[0]), .ext_irq_1_n(irqN[1]),
    .ext_irq_2_n(irqN[2]), .ext_irq_3_n(irqN[3]), .nmiN(irqN[4]));
  deb_ext_mem u_mem (.*);

  // 10 MHz core clock
  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end
  // Hang guard
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      give_verdict();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic give_verdict();
    $display("checked %0d, failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    regAddr <= a;
    regWdata <= d;
    regWr <= 1'b1;
    @(posedge sys_clk);
    regWr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge sys_clk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge sys_clk);
    regRd <= 1'b0;
    @(negedge sys_clk);
    d = regRdata;
  endtask
  // Held until taken; latency counted from the take edge
  task automatic acc(input deb_row_t r, output logic [15:0] d, output int n);
    @(posedge sys_clk);
    reqValid <= 1'b1;
    reqSpace <= r.sp;
    reqWrite <= r.wr;
    reqAddr <= r.a;
    reqWdata <= r.wd;
    for (n = 0; n < 50; n++) begin
      @(negedge sys_clk);
      if (reqReady === 1'b1) break;
    end
    @(posedge sys_clk);
    reqValid <= 1'b0;
    for (n = 0; n < 60; n++) begin
      @(negedge sys_clk);
      if (rspValid === 1'b1) break;
    end
    d = rspRdata;
  endtask
  task automatic vec(input logic [15:0] exp);
    for (int i = 0; i < 80; i++) begin
      @(negedge sys_clk);
      if (vecTaken === 1'b1) break;
    end
    chk(32'(vecTaken), 32'h1);
    chk(32'(vecAddr), 32'(exp));
  endtask
  // Three-cycle low pulse
  task automatic pulse(input logic [4:0] m);
    @(posedge sys_clk);
    irqN <= ~m;
    repeat (3) @(posedge sys_clk);
    irqN <= 5'h1f;
  endtask

  initial begin
    repeat (5) @(posedge sys_clk);
    rstn <= 1'b1;
    repeat (4) @(posedge sys_clk);
    // Read-only and unmapped writes leave no trace
    wr(8'h10, 32'hffffffff);
    wr(8'h20, 32'hffffffff);
    for (int i = 0; i < 6; i++) begin
      rd(regs[i], rv);
      chk(rv, rstv[i]);
    end
    foreach (rows[i]) begin
      acc(rows[i], rdw, lat);
      if (!rows[i].wr) chk(32'(rdw), 32'(rows[i].rd));
      chk(32'(lastAddr), 32'(rows[i].seen));
      chk(32'(lat), 32'h3);
    end
    // Two wait states: stalls stretch the access
    wr(8'h00, 32'h4);
    acc(rows[3], rdw, lat);
    chk(32'(lat), 32'h5);
    slow <= 1'b1;
    acc(rows[3], rdw, lat);
    chk(32'(lat > 5), 32'h1);
    chk(32'(rdw), 32'h1234);
    // One wait state: ready ignored
    wr(8'h00, 32'h2);
    acc(rows[4], rdw, lat);
    chk(32'(lat), 32'h4);
    slow <= 1'b0;
    // Keepers hold the last written word
    wr(8'h00, 32'h1);
    acc(rows[0], rdw, lat);
    repeat (4) @(negedge sys_clk);
    chk({15'h0, bus_keeper_enable, keeperLevel}, 32'h11234);
    wr(8'h00, 32'h0);
    repeat (2) @(negedge sys_clk);
    chk(32'(bus_keeper_enable), 32'h0);
    @(posedge sys_clk);
    holdReqN <= 1'b0;
    repeat (6) @(negedge sys_clk);
    chk(32'({holdAckN, addrDrvN, dataDrvN, ctlDrvN, reqReady}), 32'h0e);
    @(posedge sys_clk);
    holdReqN <= 1'b1;
    outputDisableN <= 1'b0;
    // Disabled outputs keep a write off the pins
    acc(rows[1], rdw, lat);
    chk(32'({addrDrvN, dataDrvN, ctlDrvN, iackDrvN}), 32'hf);
    @(posedge sys_clk);
    outputDisableN <= 1'b1;
    reset_pin_n <= 1'b0;
    repeat (5) @(negedge sys_clk);
    chk(32'({dataDrvN, reqReady}), 32'h2);
    @(posedge sys_clk);
    reset_pin_n <= 1'b1;
    repeat (4) @(posedge sys_clk);
    // Pending set, masked, cleared by a one
    wr(8'h04, 32'h0);
    pulse(5'h04);
    repeat (4) @(posedge sys_clk);
    rd(8'h08, rv);
    chk(32'({rv, irqOut}), 32'h8);
    wr(8'h04, 32'h4);
    @(negedge sys_clk);
    chk(32'(irqOut), 32'h1);
    wr(8'h08, 32'h4);
    rd(8'h08, rv);
    chk(32'({rv, irqOut}), 32'h0);
    // Lower number wins; taking blocks the other
    wr(8'h04, 32'hf);
    pulse(5'h0a);
    wr(8'h0c, 32'h0);
    vec(deb_pkg::VEC_EXT_BASE + (16'h1 << deb_pkg::VEC_STRIDE_SHIFT));
    rd(8'h0c, rv);
    chk(rv, 32'h1);
    wr(8'h0c, 32'h0);
    vec(deb_pkg::VEC_EXT_BASE + (16'h3 << deb_pkg::VEC_STRIDE_SHIFT));
    // Non-maskable while all masked
    wr(8'h04, 32'h0);
    pulse(5'h10);
    vec(deb_pkg::VEC_NMI);
    give_verdict();
  end
endmodule
bind deb_ext_bus deb_ext_bus_props #(.WAIT_W(WAIT_W)) u_props (.*);
`default_nettype wire
